// [hw/eft_top.sv]
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "eft_regs.svh"

module eft_top
    import eft_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `EFT_MS_NS / `EFT_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] fwd_fault_ph,
    input wire logic rev_fault,
    input wire logic nondir_fault,
    input wire logic ef_pickup,
    input wire logic ef_trip_cmd,
    input wire logic jump_det,
    input wire logic switch_binary,
    input wire logic [2:0] unblock_freq_received,
    input wire logic [2:0] monitor_freq_received,
    input wire logic [2:0] block_received,
    output logic [2:0] send_key,
    output logic [2:0] trip_release,
    output logic weak_infeed_act,
    output logic [2:0] channel_failure_alarm,
    output logic tele_active,
    output logic transient_block
);
    localparam int unsigned SYN_W = 18;

    logic [SYN_W-1:0] sync1_q, sync2_q;
    logic [9:0] ctrl_q;
    logic [15:0] ts_set_q, tv_set_q, tw_set_q, th_set_q;
    logic [16:0] ms_cnt_q;
    logic tick;
    logic [2:0] fwd_s, ub_s, mon_s, blk_s;
    logic rev_s, nondir_s, pickup_s, trip_s, jump_s, swbin_s;
    eft_mode_t mode;
    logic mode_ub, mode_blk, active, three, seg;
    logic [2:0] lane_en, unb_rel, hold_q, alarm_q, send_q, trip_q;
    logic [2:0] send_d, trip_d;
    logic fwd_any, blk_start, wi_q, active_q, tb_q;
    logic [15:0] pu_age_q, tb_cnt_q;
    logic tb_crit, tb_now;
    logic [13:0] lost_ms_q [3];
    logic [6:0] pu_ms_q [3];
    logic [6:0] do_ms_q [3];
    logic [15:0] ts_ms_q [3];
    logic [15:0] tv_ms_q [3];
    logic [31:0] rdata_d;
    logic addr_ok, ro_hit;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    // Every scheme input pin passes two flip-flops before any logic looks at it; the APB pins do not.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {fwd_fault_ph, rev_fault, nondir_fault, ef_pickup, ef_trip_cmd,
                        jump_det, switch_binary, unblock_freq_received,
                        monitor_freq_received, block_received};
            sync2_q <= sync1_q;
        end
    end

    assign {fwd_s, rev_s, nondir_s, pickup_s, trip_s, jump_s, swbin_s, ub_s, mon_s, blk_s}
        = sync2_q;

    // Configuration decode.
    assign mode = eft_mode_t'(ctrl_q[`EFT_CTRL_MODE_LSB +: 2]);
    // Code 3 selects no scheme, so it must count as off like code 0.
    assign active = ctrl_q[`EFT_CTRL_SW_PARAM] & ctrl_q[`EFT_CTRL_SW_SYSIF] & swbin_s
                    & ((mode == EFT_MODE_UNBLOCK) | (mode == EFT_MODE_BLOCKING));
    assign mode_ub = active & (mode == EFT_MODE_UNBLOCK);
    assign mode_blk = active & (mode == EFT_MODE_BLOCKING);
    assign three = ctrl_q[`EFT_CTRL_THREE_TERM];
    assign seg = ctrl_q[`EFT_CTRL_PHASE_SEG] & ~three;
    assign lane_en = three ? 3'h3 : (seg ? 3'h7 : 3'h1);
    // Only a stage configured forward directional may feed the scheme.
    assign fwd_any = |fwd_s & ctrl_q[`EFT_CTRL_STAGE_FWD] & active;
    assign blk_start = rev_s | (ctrl_q[`EFT_CTRL_JUMP_EN] & jump_s);

    // Common millisecond tick; all scheme timers count it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_q <= '0;
        end else if (ms_cnt_q == 17'(MS_CYCLES - 1)) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 17'h00001;
        end
    end

    assign tick = (ms_cnt_q == 17'(MS_CYCLES - 1));

    // Age of the pickup, so early reverse decisions can be told from late ones.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_age_q <= '0;
        end else if (!pickup_s || !active) begin
            pu_age_q <= '0;
        end else if (tick && pu_age_q != 16'hFFFF) begin
            pu_age_q <= pu_age_q + 16'h0001;
        end
    end

    // Transient blocking: stays armed while the criterion lasts, then hold time.
    assign tb_crit = active & (nondir_s | rev_s)
                     & ((pickup_s & (pu_age_q < tw_set_q)) | (tb_cnt_q != '0));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_cnt_q <= '0;
        end else if (!active) begin
            tb_cnt_q <= '0;
        end else if (tb_crit) begin
            tb_cnt_q <= th_set_q;
        end else if (tick && tb_cnt_q != '0) begin
            tb_cnt_q <= tb_cnt_q - 16'h0001;
        end
    end

    assign tb_now = tb_crit | (tb_cnt_q != '0);

    a_trans_block_set: assert property (@(posedge pclk) disable iff (!presetn)
        tb_crit |=> transient_block)
        else $error("transient block not raised by early reverse fault");

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_lane
            logic both_lost, lost20, fwd_p, rx_ok, blk_rx;

            // One unblock logic per receive channel.
            assign both_lost = ~ub_s[g] & ~mon_s[g];
            assign lost20 = lost_ms_q[g] >= 14'(`EFT_UB_DELAY_MS);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lost_ms_q[g] <= '0;
                end else if (!mode_ub || !lane_en[g] || !both_lost) begin
                    lost_ms_q[g] <= '0;
                end else if (tick && lost_ms_q[g] <= 14'(`EFT_FAIL_MS)) begin
                    lost_ms_q[g] <= lost_ms_q[g] + 14'h0001;
                end
            end

            // Pickup half of the 100/100 stage withdraws the loss release.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pu_ms_q[g] <= '0;
                    do_ms_q[g] <= '0;
                    hold_q[g] <= 1'b0;
                end else if (!mode_ub || !lane_en[g]) begin
                    pu_ms_q[g] <= '0;
                    do_ms_q[g] <= '0;
                    hold_q[g] <= 1'b0;
                end else if (!hold_q[g]) begin
                    do_ms_q[g] <= '0;
                    if (!lost20) begin
                        pu_ms_q[g] <= '0;
                    end else if (pu_ms_q[g] == 7'(`EFT_UB_PICKUP_MS)) begin
                        hold_q[g] <= 1'b1;
                        pu_ms_q[g] <= '0;
                    end else if (tick) begin
                        pu_ms_q[g] <= pu_ms_q[g] + 7'h01;
                    end
                end else begin
                    if (both_lost) begin
                        do_ms_q[g] <= '0;
                    end else if (do_ms_q[g] == 7'(`EFT_UB_DROPOUT_MS)) begin
                        hold_q[g] <= 1'b0;
                        do_ms_q[g] <= '0;
                    end else if (tick) begin
                        do_ms_q[g] <= do_ms_q[g] + 7'h01;
                    end
                end
            end

            // Direct path for a clean unblock, delayed path for a dead channel.
            assign unb_rel[g] = mode_ub & lane_en[g] & ~hold_q[g]
                                & ((ub_s[g] & ~mon_s[g]) | lost20);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    alarm_q[g] <= 1'b0;
                end else begin
                    alarm_q[g] <= lost_ms_q[g] > 14'(`EFT_FAIL_MS);
                end
            end

            // Per-phase forward decision; one shared path when not segregated.
            assign fwd_p = (seg ? fwd_s[g] : |fwd_s) & ctrl_q[`EFT_CTRL_STAGE_FWD] & active;
            assign rx_ok = three ? (unb_rel[0] & unb_rel[1])
                                 : (seg ? unb_rel[g] : unb_rel[0]);
            assign blk_rx = tb_now | (three ? (blk_s[0] | blk_s[1])
                                            : (seg ? blk_s[g] : blk_s[0]));

            // Send prolongation; permissive use needs a trip already issued.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ts_ms_q[g] <= '0;
                end else if (!active) begin
                    ts_ms_q[g] <= '0;
                end else if (mode_ub && fwd_p && trip_s) begin
                    ts_ms_q[g] <= ts_set_q;
                end else if (mode_blk && blk_start && !fwd_any) begin
                    ts_ms_q[g] <= ts_set_q;
                end else if (mode_blk && fwd_any) begin
                    ts_ms_q[g] <= '0;
                end else if (tick && ts_ms_q[g] != '0) begin
                    ts_ms_q[g] <= ts_ms_q[g] - 16'h0001;
                end
            end

            // Blocking trip delay runs while forward and nothing blocks.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tv_ms_q[g] <= '0;
                end else if (!mode_blk || !fwd_p || blk_rx) begin
                    tv_ms_q[g] <= '0;
                end else if (tick && tv_ms_q[g] < tv_set_q) begin
                    tv_ms_q[g] <= tv_ms_q[g] + 16'h0001;
                end
            end

            // Key high means unblock frequency or blocking signal.
            always_comb begin
                send_d[g] = 1'b0;
                trip_d[g] = 1'b0;
                if (mode_ub) begin
                    send_d[g] = (fwd_p | (ts_ms_q[g] != '0)) & ~tb_now;
                    trip_d[g] = fwd_p & rx_ok & ~tb_now;
                end else if (mode_blk) begin
                    send_d[g] = (blk_start | (ts_ms_q[g] != '0)) & ~fwd_any;
                    trip_d[g] = fwd_p & ~blk_rx & (tv_ms_q[g] >= tv_set_q);
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    send_q[g] <= 1'b0;
                    trip_q[g] <= 1'b0;
                end else begin
                    send_q[g] <= send_d[g];
                    trip_q[g] <= trip_d[g];
                end
            end
        end
    endgenerate

    // Weak infeed: any enabled remote end signals while we saw nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wi_q <= 1'b0;
            active_q <= 1'b0;
            tb_q <= 1'b0;
        end else begin
            wi_q <= mode_ub & ~pickup_s & (|(unb_rel & lane_en));
            active_q <= active;
            tb_q <= tb_now;
        end
    end

    assign send_key = send_q;
    assign trip_release = trip_q;
    assign weak_infeed_act = wi_q;
    assign channel_failure_alarm = alarm_q;
    assign tele_active = active_q;
    assign transient_block = tb_q;

    // APB: answer one cycle after setup, so the access phase has no wait.
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `EFT_OFS_STATUS);
    assign ro_hit = (paddr == `EFT_OFS_STATUS);
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `EFT_OFS_CTRL: rdata_d = {22'h000000, ctrl_q};
            `EFT_OFS_SEND_PROLONG: rdata_d = {16'h0000, ts_set_q};
            `EFT_OFS_TRIP_DELAY: rdata_d = {16'h0000, tv_set_q};
            `EFT_OFS_TRANS_WAIT: rdata_d = {16'h0000, tw_set_q};
            `EFT_OFS_TRANS_HOLD: rdata_d = {16'h0000, th_set_q};
            `EFT_OFS_STATUS: rdata_d = {17'h00000, hold_q, wi_q, trip_q, send_q,
                                        alarm_q, tb_q, active_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & (~addr_ok | (pwrite & ro_hit));
            prdata_q <= (psel & ~penable & ~pwrite & addr_ok) ? rdata_d : 32'h0000_0000;
        end
    end

    // Writes land in the access cycle, the only cycle pready is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `EFT_CTRL_RST;
            ts_set_q <= `EFT_SEND_PROLONG_RST;
            tv_set_q <= `EFT_TRIP_DELAY_RST;
            tw_set_q <= `EFT_TRANS_WAIT_RST;
            th_set_q <= `EFT_TRANS_HOLD_RST;
        end else if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                `EFT_OFS_CTRL: ctrl_q <= pwdata[9:0];
                `EFT_OFS_SEND_PROLONG: ts_set_q <= pwdata[15:0];
                `EFT_OFS_TRIP_DELAY: tv_set_q <= pwdata[15:0];
                `EFT_OFS_TRANS_WAIT: tw_set_q <= pwdata[15:0];
                `EFT_OFS_TRANS_HOLD: th_set_q <= pwdata[15:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Checks on the scheme logic and the APB ready timing.
    // Lane 0 stands for the others, as every lane is the same generated logic.
    logic alarm_src0;
    assign alarm_src0 = lost_ms_q[0] > 14'(`EFT_FAIL_MS);

    a_loss_release_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_ub && lane_en[0] && !hold_q[0] && lost_ms_q[0] >= 14'(`EFT_UB_DELAY_MS))
        |-> unb_rel[0])
        else $error("loss release missing after security delay");
    a_loss_release_gone: assert property (@(posedge pclk) disable iff (!presetn)
        (hold_q[0] && !ub_s[0] && !mon_s[0]) |-> !unb_rel[0])
        else $error("loss release not withdrawn by timer stage");
    // The loss counter runs on the same ticks, so it tells how long the release stood.
    a_loss_hold_age: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(hold_q[0]) |-> ($past(lost_ms_q[0])
                              >= 14'(`EFT_UB_DELAY_MS + `EFT_UB_PICKUP_MS)))
        else $error("loss release withdrawn before the timer stage ran out");
    a_channel_alarm: assert property (@(posedge pclk) disable iff (!presetn)
        channel_failure_alarm[0] |-> $past(alarm_src0))
        else $error("channel alarm without long loss");
    a_block_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_blk && fwd_any) |=> (send_key == 3'h0))
        else $error("blocking signal sent during forward fault");
    a_block_trip_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_blk && trip_d[0]) |-> (tv_ms_q[0] >= tv_set_q && !tb_now))
        else $error("blocking trip before delay or while blocked");
    a_three_and: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_ub && three && trip_d[0]) |-> (unb_rel[0] && unb_rel[1]))
        else $error("three terminal release without both ends");
    a_inactive_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !active |=> (send_key == 3'h0 && trip_release == 3'h0))
        else $error("scheme output while switched off");
    a_prolong_trip: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_ub && ts_ms_q[0] > $past(ts_ms_q[0])) |-> $past(trip_s))
        else $error("send prolonged without prior trip");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready not one cycle after setup");
endmodule

`default_nettype wire

// [hw/eft_regs.svh]
`ifndef EFT_REGS_SVH
`define EFT_REGS_SVH

// Register byte offsets.
`define EFT_OFS_CTRL 8'h00
`define EFT_OFS_SEND_PROLONG 8'h04
`define EFT_OFS_TRIP_DELAY 8'h08
`define EFT_OFS_TRANS_WAIT 8'h0C
`define EFT_OFS_TRANS_HOLD 8'h10
`define EFT_OFS_STATUS 8'h14

// Control field positions.
`define EFT_CTRL_SW_PARAM 0
`define EFT_CTRL_SW_SYSIF 1
`define EFT_CTRL_MODE_LSB 4
`define EFT_CTRL_THREE_TERM 6
`define EFT_CTRL_PHASE_SEG 7
`define EFT_CTRL_JUMP_EN 8
`define EFT_CTRL_STAGE_FWD 9

// Reset values.
`define EFT_CTRL_RST 10'h000
`define EFT_SEND_PROLONG_RST 16'h0032
`define EFT_TRIP_DELAY_RST 16'h0014
`define EFT_TRANS_WAIT_RST 16'h0028
`define EFT_TRANS_HOLD_RST 16'h0050

// Timing, in the units named.
`define EFT_CLK_NS 10
`define EFT_MS_NS 1000000
`define EFT_UB_DELAY_MS 20
`define EFT_UB_PICKUP_MS 100
`define EFT_UB_DROPOUT_MS 100
`define EFT_FAIL_MS 10000

`endif

// [hw/eft_pkg.sv]
package eft_pkg;
    // Scheme selected in the control register.
    typedef enum logic [1:0] {
        EFT_MODE_OFF,
        EFT_MODE_UNBLOCK,
        EFT_MODE_BLOCKING
    } eft_mode_t;
endpackage

// [verif/eft_chan_model.sv]
`timescale 1ns/10ps
`default_nettype none

module eft_chan_model #(
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] link_up,
    input wire logic [2:0] remote_key,
    input wire logic [2:0] remote_block,
    input wire logic slow,
    output logic [2:0] unblock_freq_received,
    output logic [2:0] monitor_freq_received,
    output logic [2:0] block_received
);
    logic [8:0] tone_d;
    logic [8:0] line_q [0:DEPTH-1];

    // A dead link carries no tone at all, so both indications drop together.
    assign tone_d = {link_up & remote_block, link_up & ~remote_key, link_up & remote_key};

    // Transit delay of the carrier; the slow setting models a long channel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                line_q[i] <= 9'h000;
            end
        end else begin
            line_q[0] <= tone_d;
            for (int i = 1; i < DEPTH; i++) begin
                line_q[i] <= line_q[i-1];
            end
        end
    end

    // Receive indications seen by the relay after the chosen transit delay.
    assign {block_received, monitor_freq_received, unblock_freq_received} =
        slow ? line_q[DEPTH-1] : line_q[0];
endmodule

`default_nettype wire

// [verif/eft_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eft_regs.svh"

module eft_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] fwd_fault_ph, unblock_freq_received, monitor_freq_received, block_received;
    logic rev_fault, nondir_fault, ef_pickup, ef_trip_cmd, jump_det, switch_binary, er;
    logic [2:0] send_key, trip_release, channel_failure_alarm, link_up, remote_key, remote_block;
    logic weak_infeed_act, tele_active, transient_block, slow;
    int err_total;
    int total_checks;

    // Two clock cycles per millisecond tick keeps the ten second alarm affordable.
    eft_top #(.MS_CYCLES(2)) i_eft_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fwd_fault_ph(fwd_fault_ph), .rev_fault(rev_fault),
        .nondir_fault(nondir_fault), .ef_pickup(ef_pickup), .ef_trip_cmd(ef_trip_cmd),
        .jump_det(jump_det), .switch_binary(switch_binary),
        .unblock_freq_received(unblock_freq_received),
        .monitor_freq_received(monitor_freq_received), .block_received(block_received),
        .send_key(send_key), .trip_release(trip_release), .weak_infeed_act(weak_infeed_act),
        .channel_failure_alarm(channel_failure_alarm), .tele_active(tele_active),
        .transient_block(transient_block));

    eft_chan_model i_eft_chan_model (.pclk(pclk), .presetn(presetn), .link_up(link_up),
        .remote_key(remote_key), .remote_block(remote_block), .slow(slow),
        .unblock_freq_received(unblock_freq_received),
        .monitor_freq_received(monitor_freq_received), .block_received(block_received));

    // Clock at 100 MHz.
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    // Only the watchdog ends a wait, so a silent slave shows up as a timeout.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic ms(input int n);
        repeat (n * 2) @(posedge pclk);
    endtask

    // Covers the two synchroniser stages and the output register.
    task automatic st();
        repeat (6) @(posedge pclk);
    endtask

    task automatic t_regs();
        logic [31:0] exp [0:4];
        exp = '{32'h0, 32'(`EFT_SEND_PROLONG_RST), 32'(`EFT_TRIP_DELAY_RST),
                32'(`EFT_TRANS_WAIT_RST), 32'(`EFT_TRANS_HOLD_RST)};
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            chk(rd, exp[i]);
            chk(er, 32'h0);
        end
        apb(1'h0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        chk(er, 32'h1);
        apb(1'h1, 8'h02, 32'h5);
        chk(er, 1'h1);
        apb(1'h1, `EFT_OFS_STATUS, 32'h7FFF);
        chk(er, 1'h1);
        $display("test regs done");
    endtask

    task automatic t_unblock();
        @(posedge pclk);
        link_up <= 3'h7;
        remote_key <= 3'h0;
        switch_binary <= 1'h1;
        fwd_fault_ph <= 3'h7;
        apb(1'h1, 8'h00, 32'h211);
        st();
        chk({tele_active, send_key}, 4'h0);
        apb(1'h1, 8'h00, 32'h233);
        st();
        chk({tele_active, send_key}, 4'h0);
        apb(1'h1, 8'h00, 32'h013);
        st();
        chk(send_key, 3'h0);
        apb(1'h1, 8'h00, 32'h213);
        st();
        chk({tele_active, send_key, trip_release}, 7'h78);
        remote_key <= 3'h1;
        st();
        chk(trip_release, 3'h7);
        fwd_fault_ph <= 3'h0;
        rev_fault <= 1'h1;
        st();
        chk({send_key, trip_release}, 6'h0);
        rev_fault <= 1'h0;
        st();
        chk(weak_infeed_act, 1'h1);
        fwd_fault_ph <= 3'h7;
        ef_trip_cmd <= 1'h1;
        st();
        fwd_fault_ph <= 3'h0;
        ms(40);
        chk(send_key, 3'h7);
        ms(15);
        chk(send_key, 3'h0);
        ef_trip_cmd <= 1'h0;
        $display("test unblock done");
    endtask

    task automatic t_loss();
        @(posedge pclk);
        slow <= 1'h1;
        remote_key <= 3'h0;
        fwd_fault_ph <= 3'h7;
        link_up <= 3'h0;
        ms(15);
        chk(trip_release, 3'h0);
        ms(10);
        chk(trip_release, 3'h7);
        ms(90);
        chk(trip_release, 3'h7);
        ms(10);
        chk(trip_release, 3'h0);
        link_up <= 3'h7;
        remote_key <= 3'h1;
        ms(90);
        chk(trip_release, 3'h0);
        ms(15);
        chk(trip_release, 3'h7);
        slow <= 1'h0;
        $display("test loss done");
    endtask

    task automatic t_three();
        apb(1'h1, 8'h00, 32'h253);
        remote_key <= 3'h1;
        st();
        chk({send_key[1:0], trip_release}, 5'h18);
        remote_key <= 3'h3;
        st();
        chk(trip_release, 3'h7);
        link_up <= 3'h5;
        ms(10050);
        chk(channel_failure_alarm[1:0], 2'h2);
        link_up <= 3'h0;
        ms(9990);
        chk(channel_failure_alarm[0], 1'h0);
        ms(15);
        chk(channel_failure_alarm[0], 1'h1);
        link_up <= 3'h7;
        $display("test three terminals done");
    endtask

    task automatic t_block();
        apb(1'h1, 8'h00, 32'h223);
        fwd_fault_ph <= 3'h0;
        remote_block <= 3'h0;
        rev_fault <= 1'h1;
        st();
        chk(send_key, 3'h7);
        rev_fault <= 1'h0;
        ms(40);
        chk(send_key, 3'h7);
        ms(15);
        chk(send_key, 3'h0);
        rev_fault <= 1'h1;
        st();
        rev_fault <= 1'h0;
        fwd_fault_ph <= 3'h7;
        st();
        chk(send_key, 3'h0);
        ms(12);
        chk(trip_release, 3'h0);
        ms(12);
        chk(trip_release, 3'h7);
        remote_block <= 3'h1;
        st();
        chk(trip_release, 3'h0);
        apb(1'h1, 8'h00, 32'h323);
        fwd_fault_ph <= 3'h0;
        jump_det <= 1'h1;
        st();
        chk(send_key, 3'h7);
        $display("test blocking done");
    endtask

    // Early non-directional decision after pickup holds the scheme off, then lets go.
    task automatic t_trans();
        apb(1'h1, 8'h00, 32'h213);
        jump_det <= 1'h0;
        remote_block <= 3'h0;
        remote_key <= 3'h1;
        fwd_fault_ph <= 3'h7;
        ef_pickup <= 1'h1;
        nondir_fault <= 1'h1;
        st();
        chk({transient_block, send_key, trip_release}, 7'h40);
        nondir_fault <= 1'h0;
        ms(70);
        chk({transient_block, send_key, trip_release}, 7'h40);
        ms(15);
        chk({transient_block, weak_infeed_act, send_key, trip_release}, 8'h3F);
        fwd_fault_ph <= 3'h2;
        remote_key <= 3'h2;
        apb(1'h1, 8'h00, 32'h293);
        st();
        chk({send_key, trip_release}, 6'h12);
        $display("test transient done");
    endtask

    // Hang guard, sized well above the alarm scenario.
    initial begin
        repeat (80000) @(posedge pclk);
        err_total++;
        conclude();
    end

    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        {fwd_fault_ph, rev_fault, nondir_fault, ef_pickup, ef_trip_cmd, jump_det} = 8'h0;
        {switch_binary, link_up, remote_key, remote_block, slow} = 11'h0;
        err_total = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        chk({send_key, trip_release, tele_active}, 7'h0);
        t_regs();
        t_unblock();
        t_loss();
        t_three();
        t_block();
        t_trans();
        conclude();
    end
endmodule

`default_nettype wire
